// file: design/i2c_target_consts.svh
`ifndef I2C_TARGET_CONSTS_SVH
`define I2C_TARGET_CONSTS_SVH

// ----------------------------------------
// Bus address
// ----------------------------------------
`define ADDR_PREFIX       5'h0D
`define STRAP_GND         2'h0
`define STRAP_SCL         2'h1
`define STRAP_SDA         2'h2
`define STRAP_VCC         2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_SYS_MHZ       25
`define SCL_MAX_KHZ       1000
`define STRAP_SETTLE_CYC  8'h10

`endif

// file: design/i2c_target_pkg.sv
package i2c_target_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_RXBYTE,
        ST_TXBYTE,
        ST_MACK,
        ST_IGNORE
    } link_state_t;

    typedef enum logic [1:0] {
        PH_DEVADDR,
        PH_REGADDR,
        PH_DATA
    } byte_phase_t;
endpackage

// file: design/sync2.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Two-flop level synchroniser
// ----------------------------------------
module sync2 (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output var  logic q
);
    logic meta_reg;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_reg <= 1'b0;
            q        <= 1'b0;
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

`default_nettype wire

// file: design/toggle_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Toggle event crossing
// ----------------------------------------
module toggle_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic tog_in,
    output var  logic pulse
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            pulse  <= 1'b0;
        end
        else
        begin
            s1_reg <= tog_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            pulse  <= s2_reg ^ s3_reg;
        end
    end
endmodule

`default_nettype wire

// file: design/i2c_target_port.sv
// Function
// - Answer to address prefix 01101, then two strap bits, then direction bit.
// - Direction bit 0 means write, 1 means read; act on it.
// - Strap to ground gives 00, to clock 01, to data 10.
// - Never drive clock; data only pulled low, released otherwise.
// - Data sampled while clock high; idle line high from master.
// - Data falling while clock high is START; begin address compare.
// - Pull data low in ninth pulse when address matched.
// - In write, register address byte follows and is acknowledged.
// - Data bytes MSB first, each acknowledged by the device.
// - Data rising while clock high is STOP; ends transfer.
// - Register pointer increments by one at each written byte acknowledge.
// - Read: write register address, repeated START, address with read bit.
// - Serial clock accepted up to 1 MHz.
// - Registers readable; write-only ones may return anything.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_target_consts.svh"

module i2c_target_port (
    input  wire logic       CLK_SYS,
    input  wire logic       RSTN,
    input  wire logic       SCL_CLK,
    input  wire logic       SCL_IN,
    input  wire logic       SDA_IN,
    output logic            SDA_OUT,
    output logic            SDA_OE,
    input  wire logic [1:0] STRAP_LEVEL,
    output logic [1:0]      STRAP_ADDRESS_BITS,
    output logic            WR_STROBE,
    output logic [7:0]      WR_ADDR,
    output logic [7:0]      WR_DATA,
    output logic [7:0]      RD_ADDR,
    input  wire logic [7:0] RD_DATA,
    output logic            BUSY
);
    // ----------------------------------------
    // Link domain: start and stop detection
    // ----------------------------------------
    logic sda_s_reg;
    logic sda_q_reg;
    logic scl_s_reg;
    logic scl_q_reg;
    logic rst_l1_reg;
    logic rst_l2_reg;
    logic rst_l_n;

    // Reset and bus pins through two flops each
    always_ff @(posedge SCL_CLK)
    begin
        rst_l1_reg <= RSTN;
        rst_l2_reg <= rst_l1_reg;
        sda_s_reg  <= SDA_IN;
        sda_q_reg  <= sda_s_reg;
        scl_s_reg  <= SCL_IN;
        scl_q_reg  <= scl_s_reg;
    end
    assign rst_l_n = rst_l2_reg;

    logic sda_p_reg;
    logic scl_p_reg;
    logic start_ev;
    logic stop_ev;
    logic scl_rise;
    logic scl_fall;

    always_ff @(posedge SCL_CLK)
    begin
        if (!rst_l_n)
        begin
            sda_p_reg <= 1'b1;
            scl_p_reg <= 1'b1;
        end
        else
        begin
            sda_p_reg <= sda_q_reg;
            scl_p_reg <= scl_q_reg;
        end
    end

    assign start_ev = scl_q_reg && scl_p_reg && sda_p_reg && !sda_q_reg;
    assign stop_ev  = scl_q_reg && scl_p_reg && !sda_p_reg && sda_q_reg;
    assign scl_rise = scl_q_reg && !scl_p_reg;
    assign scl_fall = !scl_q_reg && scl_p_reg;

    // ----------------------------------------
    // Link domain: byte engine
    // ----------------------------------------
    i2c_target_pkg::link_state_t state_reg;
    i2c_target_pkg::byte_phase_t phase_reg;
    logic [7:0] shift_reg;
    logic [3:0] bitcnt_reg;
    logic       rnw_reg;
    logic [7:0] ptr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] waddr_reg;
    logic       wtog_reg;
    logic       sda_drv_reg;
    logic       busy_l_reg;
    logic [1:0] strap_l_reg;
    logic [1:0] strap_l1_reg;
    logic [7:0] rdat_l1_reg;
    logic [7:0] rdat_l_reg;
    logic       addr_hit;

    // Strap and read data held static by the system side
    always_ff @(posedge SCL_CLK)
    begin
        strap_l1_reg <= STRAP_ADDRESS_BITS;
        strap_l_reg  <= strap_l1_reg;
        rdat_l1_reg  <= RD_DATA;
        rdat_l_reg   <= rdat_l1_reg;
    end

    assign addr_hit = shift_reg[7:3] == `ADDR_PREFIX
                   && shift_reg[2:1] == strap_l_reg;

    always_ff @(posedge SCL_CLK)
    begin
        if (!rst_l_n)
        begin
            state_reg     <= i2c_target_pkg::ST_IDLE;
            phase_reg     <= i2c_target_pkg::PH_DEVADDR;
            shift_reg     <= 8'h00;
            bitcnt_reg    <= 4'h0;
            rnw_reg       <= 1'b0;
            ptr_reg       <= 8'h00;
            wdata_reg     <= 8'h00;
            waddr_reg     <= 8'h00;
            wtog_reg      <= 1'b0;
            sda_drv_reg   <= 1'b0;
            busy_l_reg    <= 1'b0;
        end
        else if (start_ev)
        begin
            state_reg   <= i2c_target_pkg::ST_ADDR;
            phase_reg   <= i2c_target_pkg::PH_DEVADDR;
            bitcnt_reg  <= 4'h0;
            sda_drv_reg <= 1'b0;
            busy_l_reg  <= 1'b1;
        end
        else if (stop_ev)
        begin
            state_reg   <= i2c_target_pkg::ST_IDLE;
            sda_drv_reg <= 1'b0;
            busy_l_reg  <= 1'b0;
        end
        else
        begin
            case (state_reg)
                i2c_target_pkg::ST_ADDR,
                i2c_target_pkg::ST_RXBYTE:
                begin
                    if (scl_rise)
                    begin
                        shift_reg  <= {shift_reg[6:0], sda_q_reg};
                        bitcnt_reg <= bitcnt_reg + 4'h1;
                    end
                    else if (scl_fall && bitcnt_reg == 4'h8)
                    begin
                        bitcnt_reg <= 4'h0;
                        if (phase_reg == i2c_target_pkg::PH_DEVADDR)
                        begin
                            if (addr_hit)
                            begin
                                rnw_reg       <= shift_reg[0];
                                sda_drv_reg   <= 1'b1;
                                state_reg     <= i2c_target_pkg::ST_ACK;
                            end
                            else
                            begin
                                state_reg <= i2c_target_pkg::ST_IGNORE;
                            end
                        end
                        else if (phase_reg == i2c_target_pkg::PH_REGADDR)
                        begin
                            ptr_reg     <= shift_reg;
                            sda_drv_reg <= 1'b1;
                            state_reg   <= i2c_target_pkg::ST_ACK;
                        end
                        else
                        begin
                            wdata_reg   <= shift_reg;
                            waddr_reg   <= ptr_reg;
                            wtog_reg    <= ~wtog_reg;
                            ptr_reg     <= ptr_reg + 8'h01;
                            sda_drv_reg <= 1'b1;
                            state_reg   <= i2c_target_pkg::ST_ACK;
                        end
                    end
                end
                i2c_target_pkg::ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (phase_reg == i2c_target_pkg::PH_DEVADDR && rnw_reg)
                        begin
                            shift_reg   <= {rdat_l_reg[6:0], 1'b1};
                            sda_drv_reg <= !rdat_l_reg[7];
                            bitcnt_reg  <= 4'h1;
                            state_reg   <= i2c_target_pkg::ST_TXBYTE;
                        end
                        else
                        begin
                            sda_drv_reg <= 1'b0;
                            state_reg   <= i2c_target_pkg::ST_RXBYTE;
                            phase_reg   <= phase_reg == i2c_target_pkg::PH_DEVADDR
                                ? i2c_target_pkg::PH_REGADDR : i2c_target_pkg::PH_DATA;
                        end
                    end
                end
                i2c_target_pkg::ST_TXBYTE:
                begin
                    if (scl_fall)
                    begin
                        if (bitcnt_reg == 4'h8)
                        begin
                            sda_drv_reg <= 1'b0;
                            bitcnt_reg  <= 4'h0;
                            ptr_reg     <= ptr_reg + 8'h01;
                            state_reg   <= i2c_target_pkg::ST_MACK;
                        end
                        else
                        begin
                            sda_drv_reg <= !shift_reg[7];
                            shift_reg   <= {shift_reg[6:0], 1'b1};
                            bitcnt_reg  <= bitcnt_reg + 4'h1;
                        end
                    end
                end
                i2c_target_pkg::ST_MACK:
                begin
                    if (scl_rise)
                    begin
                        rnw_reg <= sda_q_reg;
                    end
                    else if (scl_fall)
                    begin
                        if (rnw_reg)
                        begin
                            state_reg <= i2c_target_pkg::ST_IGNORE;
                        end
                        else
                        begin
                            rnw_reg     <= 1'b1;
                            shift_reg   <= {rdat_l_reg[6:0], 1'b1};
                            sda_drv_reg <= !rdat_l_reg[7];
                            bitcnt_reg  <= 4'h1;
                            state_reg   <= i2c_target_pkg::ST_TXBYTE;
                        end
                    end
                end
                i2c_target_pkg::ST_IGNORE,
                i2c_target_pkg::ST_IDLE:
                begin
                    sda_drv_reg <= 1'b0;
                end
                default: state_reg <= i2c_target_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // System domain crossings and outputs
    // ----------------------------------------
    logic [7:0] ptr_x1_reg;
    logic [7:0] ptr_x2_reg;
    logic [7:0] wd_x1_reg;
    logic [7:0] wd_x2_reg;
    logic [7:0] wa_x1_reg;
    logic [7:0] wa_x2_reg;
    logic       busy_x;
    logic       wr_pulse;

    sync2 u_busy_sync (
        .clk   (CLK_SYS),
        .rst_n (RSTN),
        .d     (busy_l_reg),
        .q     (busy_x)
    );

    toggle_sync u_wr_sync (
        .clk    (CLK_SYS),
        .rst_n  (RSTN),
        .tog_in (wtog_reg),
        .pulse  (wr_pulse)
    );

    always_ff @(posedge CLK_SYS)
    begin
        ptr_x1_reg <= ptr_reg;
        ptr_x2_reg <= ptr_x1_reg;
        wd_x1_reg  <= wdata_reg;
        wd_x2_reg  <= wd_x1_reg;
        wa_x1_reg  <= waddr_reg;
        wa_x2_reg  <= wa_x1_reg;
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            WR_STROBE <= 1'b0;
            WR_ADDR   <= 8'h00;
            WR_DATA   <= 8'h00;
            RD_ADDR   <= 8'h00;
            BUSY      <= 1'b0;
        end
        else
        begin
            WR_STROBE <= wr_pulse;
            if (wr_pulse)
            begin
                WR_ADDR <= wa_x2_reg;
                WR_DATA <= wd_x2_reg;
            end
            if (ptr_x1_reg == ptr_x2_reg)
                RD_ADDR <= ptr_x2_reg;
            BUSY    <= busy_x;
        end
    end

    // ----------------------------------------
    // Strap capture after reset release
    // ----------------------------------------
    logic [1:0] strap_s1_reg;
    logic [1:0] strap_s2_reg;
    logic [7:0] settle_reg;

    always_ff @(posedge CLK_SYS)
    begin
        strap_s1_reg <= STRAP_LEVEL;
        strap_s2_reg <= strap_s1_reg;
        if (!RSTN)
        begin
            settle_reg         <= 8'h00;
            STRAP_ADDRESS_BITS <= `STRAP_GND;
        end
        else if (settle_reg != `STRAP_SETTLE_CYC)
        begin
            settle_reg         <= settle_reg + 8'h01;
            STRAP_ADDRESS_BITS <= strap_s2_reg;
        end
    end

    // ----------------------------------------
    // Open-drain data pin
    // ----------------------------------------
    always_ff @(posedge SCL_CLK)
    begin
        if (!rst_l_n)
        begin
            SDA_OE  <= 1'b0;
            SDA_OUT <= 1'b0;
        end
        else
        begin
            SDA_OE  <= sda_drv_reg;
            SDA_OUT <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// file: test/i2c_target_port_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Port checker
// ----------------------------------------
module i2c_target_port_chk (
    input  wire logic       CLK_SYS,
    input  wire logic       RSTN,
    input  wire logic       SCL_CLK,
    input  wire logic       SCL_IN,
    input  wire logic       SDA_OUT,
    input  wire logic       SDA_OE,
    input  wire logic [1:0] STRAP_LEVEL,
    input  wire logic [1:0] STRAP_ADDRESS_BITS,
    input  wire logic       WR_STROBE,
    input  wire logic [7:0] WR_ADDR,
    input  wire logic [7:0] WR_DATA,
    input  wire logic [7:0] RD_ADDR,
    input  wire logic       BUSY
);
    logic [7:0] up_cnt_reg;

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
            up_cnt_reg <= 8'h00;
        else if (up_cnt_reg != 8'hFF)
            up_cnt_reg <= up_cnt_reg + 8'h01;
    end

    a_sda_pull_only: assert property (@(posedge SCL_CLK) disable iff (!RSTN)
        SDA_OUT == 1'b0) else $error("data line driven high");
    a_oe_hold_high: assert property (@(posedge SCL_CLK) disable iff (!RSTN)
        SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE)) else $error("data changed in clock high");
    a_ack_when_low: assert property (@(posedge SCL_CLK) disable iff (!RSTN)
        $rose(SDA_OE) |-> !SCL_IN ##1 !SCL_IN) else $error("pull-down began outside clock low");
    a_ack_release_low: assert property (@(posedge SCL_CLK) disable iff (!RSTN)
        $fell(SDA_OE) |-> !SCL_IN) else $error("pull-down ended outside clock low");
    a_strobe_single: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        WR_STROBE |=> !WR_STROBE) else $error("write strobe longer than one cycle");
    a_wr_data_hold: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        WR_STROBE |=> $stable(WR_ADDR) && $stable(WR_DATA)) else $error("write data moved");
    a_strobe_in_busy: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        WR_STROBE |-> BUSY) else $error("write strobe outside transfer");
    a_ptr_step_one: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        WR_STROBE |-> ##[0:40] RD_ADDR == WR_ADDR + 8'h01) else $error("pointer did not step");
    a_strap_match: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        up_cnt_reg == 8'h20 |-> STRAP_ADDRESS_BITS == STRAP_LEVEL) else $error("strap bits wrong");
    a_busy_low_reset: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        up_cnt_reg < 8'h04 |-> !BUSY) else $error("busy high right after reset");
endmodule

bind i2c_target_port i2c_target_port_chk chk (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .SCL_CLK(SCL_CLK), .SCL_IN(SCL_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .STRAP_LEVEL(STRAP_LEVEL),
    .STRAP_ADDRESS_BITS(STRAP_ADDRESS_BITS), .WR_STROBE(WR_STROBE), .WR_ADDR(WR_ADDR),
    .WR_DATA(WR_DATA), .RD_ADDR(RD_ADDR), .BUSY(BUSY)
);

`default_nettype wire

// file: test/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Bus host model
// ----------------------------------------
module i2c_host_model #(
    parameter int HALF = 640
) (
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        #HALF;
        scl = 1'b1;
        #HALF;
        r = sda_line;
        scl = 1'b0;
        #(HALF / 4);
    endtask

    task automatic start_cond();
        sda_low = 1'b0;
        #HALF;
        scl = 1'b1;
        #HALF;
        sda_low = 1'b1;
        #HALF;
        scl = 1'b0;
        #(HALF / 4);
    endtask

    task automatic stop_cond();
        sda_low = 1'b1;
        #HALF;
        scl = 1'b1;
        #HALF;
        sda_low = 1'b0;
        #HALF;
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask
endmodule

`default_nettype wire

// file: test/tb_led_driver_i2c_target_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2c_target_consts.svh"

// ----------------------------------------
// Bench for the serial target port
// ----------------------------------------
module tb_led_driver_i2c_target_port;
    logic        clk_sys = 1'b0;
    logic        link_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [1:0]  strap = 2'h0;
    logic [7:0]  rd_data = 8'h00;
    logic        scl;
    logic        sda_low;
    logic        sda_line;
    logic        sda_out;
    logic        sda_oe;
    logic [1:0]  strap_bits;
    logic        wr_strobe;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic [7:0]  rd_addr;
    logic        busy;
    int          fails = 0;
    int          comparisons = 0;
    int          seed = 11802;
    int          n;
    logic [15:0] wq[$];
    logic [7:0]  dq[$];
    logic        ack;
    logic [7:0]  reg_a;
    logic [7:0]  b0;
    logic [7:0]  b1;

    always #20 clk_sys = ~clk_sys;
    always #32 link_clk = ~link_clk;

    // Open-drain data line with pull-up
    assign sda_line = (sda_low || sda_oe) ? 1'b0 : 1'b1;

    i2c_target_port uut (
        .CLK_SYS            (clk_sys),
        .RSTN               (rstn),
        .SCL_CLK            (link_clk),
        .SCL_IN             (scl),
        .SDA_IN             (sda_line),
        .SDA_OUT            (sda_out),
        .SDA_OE             (sda_oe),
        .STRAP_LEVEL        (strap),
        .STRAP_ADDRESS_BITS (strap_bits),
        .WR_STROBE          (wr_strobe),
        .WR_ADDR            (wr_addr),
        .WR_DATA            (wr_data),
        .RD_ADDR            (rd_addr),
        .RD_DATA            (rd_data),
        .BUSY               (busy)
    );

    i2c_host_model host (
        .sda_line (sda_line),
        .scl      (scl),
        .sda_low  (sda_low)
    );

    function automatic logic [7:0] reg_val(input logic [7:0] a);
        return a ^ 8'hA5;
    endfunction

    function automatic logic [7:0] dev_addr(input logic [1:0] s, input logic rd);
        return {`ADDR_PREFIX, s, rd};
    endfunction

    always @(posedge clk_sys) rd_data <= #1 reg_val(rd_addr);
    always @(posedge clk_sys) if (wr_strobe === 1'b1) wq.push_back({wr_addr, wr_data});

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic wait_bus(input int cnt);
        int k;
        for (k = 0; k < 200 && busy !== 1'b0; k++)
            @(posedge clk_sys);
        check(16'(busy), 16'h0000);
        check(16'(wq.size()), 16'(cnt));
        if (k == 200)
            report_and_stop();
    endtask

    task automatic do_reset(input logic [1:0] s);
        @(posedge clk_sys);
        #1;
        rstn = 1'b0;
        strap = s;
        repeat (8) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        repeat (20) @(posedge clk_sys);
    endtask

    task automatic send_addr_reg(input logic [1:0] s, input logic [7:0] r);
        host.start_cond();
        check(16'(busy), 16'h0001);
        host.wr_byte(dev_addr(s, 1'b0), ack);
        check(16'(ack), 16'h0001);
        host.wr_byte(r, ack);
        check(16'(ack), 16'h0001);
    endtask

    initial
    begin
        #2000000;
        fails++;
        report_and_stop();
    end

    initial
    begin
        for (int s = 0; s < 4; s++)
        begin
            do_reset(s[1:0]);
            check(16'(strap_bits), 16'(s));
            host.start_cond();
            host.wr_byte(s[0] ? {5'h0C, s[1:0], 1'b0} : dev_addr(~s[1:0], 1'b0), ack);
            check(16'(ack), 16'h0000);
            host.stop_cond();
            n = 1 + ($unsigned($random(seed)) % 4);
            reg_a = 8'($random(seed));
            dq.delete();
            send_addr_reg(s[1:0], reg_a);
            for (int i = 0; i < n; i++)
            begin
                dq.push_back(8'($random(seed)));
                host.wr_byte(dq[i], ack);
                check(16'(ack), 16'h0001);
            end
            host.stop_cond();
            wait_bus(n);
            for (int i = 0; i < n; i++)
                check(wq.pop_front(), {reg_a + 8'(i), dq[i]});
            reg_a = 8'($random(seed));
            send_addr_reg(s[1:0], reg_a);
            host.start_cond();
            host.wr_byte(dev_addr(s[1:0], 1'b1), ack);
            check(16'(ack), 16'h0001);
            host.rd_byte(1'b0, b0);
            host.rd_byte(1'b1, b1);
            host.stop_cond();
            wait_bus(0);
            check(16'(b0), 16'(reg_val(reg_a)));
            check(16'(b1), 16'(reg_val(reg_a + 8'h01)));
        end
        report_and_stop();
    end
endmodule

`default_nettype wire
